// ---- dv/dbws_rf_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Register file partner
// ----------------------------------------
module dbws_rf_model (
   input  wire logic        pclk,
   input  wire logic        rf_wr_en,
   input  wire logic [4:0]  rf_wr_addr,
   input  wire logic [2:0]  rf_wr_window,
   input  wire logic [31:0] rf_wr_data,
   output var  int          wr_cnt,
   output var  logic [39:0] last_wr
);
   logic [31:0] mem [0:255];
   initial wr_cnt = 0;
   // Window and address together pick the entry
   always @(posedge pclk) begin
      if (rf_wr_en === 1'b1) begin
         mem[{rf_wr_window, rf_wr_addr}] <= rf_wr_data;
         last_wr <= {rf_wr_window, rf_wr_addr, rf_wr_data};
         wr_cnt <= wr_cnt + 1;
      end
   end
endmodule : dbws_rf_model
`default_nettype wire

// ---- dv/delayed_branch_window_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module delayed_branch_window_sequencer_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, first_source_val, second_source_val;
   logic instr_valid, br_always, br_never, br_cond_true, annul_flag, imm_flag;
   dbws_pkg::dbws_op_type instr_op;
   logic [21:0] disp22;
   logic [29:0] disp30;
   logic [12:0] signed_immediate_field;
   logic [4:0] dest_field, rf_wr_addr, wa;
   logic [31:0] program_counter, next_program_counter, rf_wr_data, wd, pc_m, npc_m;
   logic fetch_annul, slot_exec, rf_wr_en, trap_overflow, trap_underflow;
   logic [2:0] rf_wr_window, current_window_pointer, cwp_m;
   logic [7:0] wim_m;
   logic ann_m, ov_m, un_m;
   logic [39:0] last_wr;
   int error_cnt, checks, cyc, wr_cnt;
   dbws_seq dbws_seq_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .instr_valid, .instr_op, .br_always, .br_never,
      .br_cond_true, .annul_flag, .disp22, .disp30, .imm_flag, .signed_immediate_field,
      .first_source_val, .second_source_val, .dest_field, .program_counter,
      .next_program_counter, .fetch_annul, .slot_exec, .rf_wr_en, .rf_wr_addr,
      .rf_wr_window, .rf_wr_data, .current_window_pointer, .trap_overflow,
      .trap_underflow);
   dbws_rf_model dbws_rf_model_i (.pclk, .rf_wr_en, .rf_wr_addr, .rf_wr_window,
      .rf_wr_data, .wr_cnt, .last_wr);
   initial begin
      pclk = 0;
      forever #12.5 pclk = ~pclk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk
   task automatic finish_test();
      $display("TB: checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   // Slave answers at its own pace; bounded only by the cycle ceiling
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic step();
      int o, c0;
      logic tk, an, w;
      logic [31:0] t, od, s;
      logic [2:0] nw;
      o = $urandom % 6;
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_op <= dbws_pkg::dbws_op_type'(o);
      {br_always, br_never, br_cond_true, annul_flag, imm_flag, dest_field} <= 10'($urandom);
      disp22 <= 22'($urandom);
      disp30 <= 30'($urandom);
      signed_immediate_field <= 13'($urandom);
      first_source_val <= $urandom;
      second_source_val <= $urandom;
      #1;
      an = ann_m;
      chk("fetch_annul", fetch_annul, an);
      chk("slot_exec", slot_exec, !an);
      {ann_m, tk, w, t, nw} = {35'h0, cwp_m};
      od = imm_flag ? {{19{signed_immediate_field[12]}}, signed_immediate_field}
                    : second_source_val;
      s = first_source_val + od;
      if (!an) case (o)
         1: begin
            tk = !br_never & (br_always | br_cond_true);
            t = pc_m + {{8{disp22[21]}}, disp22, 2'h0};
            ann_m = annul_flag & (!tk | br_always);
         end
         2: {tk, t, w, wa, wd} = {1'b1, pc_m + {disp30, 2'h0}, 1'b1, 5'h0F, pc_m};
         3: {tk, t, w, wa, wd} = {1'b1, s, dest_field != 5'h00, dest_field, pc_m};
         4, 5: begin
            nw = (o == 4) ? cwp_m - 3'h1 : cwp_m + 3'h1;
            if (wim_m[nw]) {ov_m, un_m} = {ov_m | (o == 4), un_m | (o == 5)};
            else {cwp_m, w, wa, wd} = {nw, dest_field != 5'h00, dest_field, s};
         end
         default: ;
      endcase
      c0 = wr_cnt;
      t = tk ? t : npc_m + 32'h4;
      {pc_m, npc_m} = {npc_m, t};
      @(posedge pclk);
      instr_valid <= 1'b0;
      #1;
      chk("pc", program_counter, pc_m);
      chk("npc", next_program_counter, npc_m);
      chk("cwp", current_window_pointer, cwp_m);
      repeat (2) @(posedge pclk);
      #1;
      chk("traps", {trap_overflow, trap_underflow}, {ov_m, un_m});
      chk("wr_cnt", wr_cnt - c0, w);
      if (w) chk("wr", last_wr, {cwp_m, wa, wd});
   endtask : step
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 12000) begin
         error_cnt++;
         finish_test();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, instr_valid, br_always, br_never} = 0;
      {br_cond_true, annul_flag, imm_flag, disp22, disp30, dest_field} = 0;
      {signed_immediate_field, first_source_val, second_source_val, presetn} = 0;
      instr_op = dbws_pkg::DBWS_OP_NONE;
      void'($urandom(37233));
      {pc_m, npc_m, cwp_m, wim_m, ann_m, ov_m, un_m} = {64'h4, 3'h0, 8'h02, 3'h0};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk("pc_rst", {program_counter, next_program_counter}, {pc_m, npc_m});
      apb(1'b0, 12'h008, 32'h0);
      chk("wim_rst", rd, 32'h0000_0002);
      apb(1'b0, 12'h014, 32'h0);
      chk("unmapped", err, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0001);
      $display("TB: reset and register test done");
      for (int n = 0; n < 400; n++) begin
         if (n % 40 == 39) begin
            apb(1'b0, 12'h004, 32'h0);
            chk("status", rd[7:0], {un_m, ov_m, ann_m, 2'h0, cwp_m});
            apb(1'b0, 12'h00C, 32'h0);
            chk("pc_reg", rd, pc_m);
            wim_m = 8'($urandom);
            apb(1'b1, 12'h008, {24'h0, wim_m});
            apb(1'b1, 12'h000, 32'h0000_0003);
            {ov_m, un_m} = 2'b00;
         end
         step();
      end
      $display("TB: instruction stream test done");
      finish_test();
   end
endmodule : delayed_branch_window_sequencer_test
`default_nettype wire

// ---- inc/dbws_pkg.sv ----
`default_nettype none
package dbws_pkg;
   typedef enum logic [2:0] {
      DBWS_OP_NONE,
      DBWS_OP_BRANCH,
      DBWS_OP_CALL,
      DBWS_OP_JUMP_AND_LINK,
      DBWS_OP_SAVE,
      DBWS_OP_RESTORE
   } dbws_op_type;
   typedef enum logic [1:0] {
      DBWS_BR_INT,
      DBWS_BR_FLOAT,
      DBWS_BR_COPROC
   } dbws_brclass_type;
endpackage : dbws_pkg
`default_nettype wire

// ---- inc/dbws_regs.svh ----
`ifndef DBWS_REGS_SVH
`define DBWS_REGS_SVH
`define DBWS_INSTR_BYTES     32'h0000_0004
`define DBWS_LINK_REG        5'h0F
`define DBWS_NWIN            5'h08
`define DBWS_CWP_MAX         3'h7
`define DBWS_RESET_PC        32'h0000_0000
`define DBWS_REG_CTRL        12'h000
`define DBWS_REG_STATUS      12'h004
`define DBWS_REG_WIM         12'h008
`define DBWS_REG_PC          12'h00C
`define DBWS_REG_NPC         12'h010
`define DBWS_CTRL_RUN_BIT    0
`define DBWS_CTRL_CLRTRAP    1
`define DBWS_WIM_RESET       32'h0000_0002
`endif

// ---- logic/dbws_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dbws_regs.svh"
module dbws_seq (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 instr_valid,
   input  wire dbws_pkg::dbws_op_type instr_op,
   input  wire logic                 br_always,
   input  wire logic                 br_never,
   input  wire logic                 br_cond_true,
   input  wire logic                 annul_flag,
   input  wire logic [21:0]          disp22,
   input  wire logic [29:0]          disp30,
   input  wire logic                 imm_flag,
   input  wire logic [12:0]          signed_immediate_field,
   input  wire logic [31:0]          first_source_val,
   input  wire logic [31:0]          second_source_val,
   input  wire logic [4:0]           dest_field,
   output logic      [31:0]          program_counter,
   output logic      [31:0]          next_program_counter,
   output logic                      fetch_annul,
   output logic                      slot_exec,
   output logic                      rf_wr_en,
   output logic      [4:0]           rf_wr_addr,
   output logic      [2:0]           rf_wr_window,
   output logic      [31:0]          rf_wr_data,
   output logic      [2:0]           current_window_pointer,
   output logic                      trap_overflow,
   output logic                      trap_underflow
);
   // -------------------------------------------------
   // Target arithmetic
   // -------------------------------------------------
   function automatic logic [31:0] sext13(input logic [12:0] v);
      sext13 = {{19{v[12]}}, v};
   endfunction : sext13
   function automatic logic [2:0] win_step(input logic [2:0] w, input logic up);
      win_step = up ? 3'(w + 3'h1) : 3'(w - 3'h1);
   endfunction : win_step
   function automatic logic [31:0] src_sum(input logic [31:0] a, input logic [31:0] b,
                                           input logic i, input logic [12:0] imm);
      src_sum = a + (i ? sext13(imm) : b);
   endfunction : src_sum

   logic        run_r;
   logic [31:0] wim_r;
   logic        annul_pend_r;
   logic        is_branch;
   logic        is_transfer;
   logic        taken;
   logic        annul_next;
   logic        win_bad;
   logic        win_op;
   logic        step;
   logic [2:0]  new_cwp;
   logic [31:0] target;
   logic [31:0] pc_nxt;
   logic [31:0] npc_nxt;
   logic [31:0] rd_mux;

   // Instruction in this cycle is live unless it is an annulled slot
   assign step        = run_r & instr_valid;
   assign slot_exec   = step & ~annul_pend_r;
   assign fetch_annul = annul_pend_r;
   assign is_branch   = (instr_op == dbws_pkg::DBWS_OP_BRANCH);
   assign is_transfer = is_branch | (instr_op == dbws_pkg::DBWS_OP_CALL)
                      | (instr_op == dbws_pkg::DBWS_OP_JUMP_AND_LINK);
   assign taken = is_branch ? ((br_always | br_cond_true) & ~br_never) : is_transfer;
   // Annul applies to branches only; always-forms annul even though taken
   assign annul_next = slot_exec & is_branch & annul_flag
                     & (br_always | br_never | ~taken);

   always_comb begin
      unique case (instr_op)
         dbws_pkg::DBWS_OP_BRANCH:
            target = program_counter + {{8{disp22[21]}}, disp22, 2'b00};
         dbws_pkg::DBWS_OP_CALL:
            target = program_counter + {disp30, 2'b00};
         dbws_pkg::DBWS_OP_JUMP_AND_LINK:
            target = src_sum(first_source_val, second_source_val,
                             imm_flag, signed_immediate_field);
         default:
            target = src_sum(first_source_val, second_source_val,
                             imm_flag, signed_immediate_field);
      endcase
   end

   assign win_op  = slot_exec & ((instr_op == dbws_pkg::DBWS_OP_SAVE)
                              | (instr_op == dbws_pkg::DBWS_OP_RESTORE));
   assign new_cwp = win_step(current_window_pointer,
                             instr_op == dbws_pkg::DBWS_OP_RESTORE);
   assign win_bad = win_op & wim_r[new_cwp];

   // Slot always comes from npc, so a preceding target is used naturally
   assign pc_nxt  = next_program_counter;
   assign npc_nxt = (slot_exec & taken & ~(is_branch & br_never))
                  ? target : next_program_counter + `DBWS_INSTR_BYTES;

   // -------------------------------------------------
   // Program counters
   // -------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_counter      <= `DBWS_RESET_PC;
         next_program_counter <= `DBWS_RESET_PC + `DBWS_INSTR_BYTES;
         annul_pend_r         <= 1'b0;
      end else if (step) begin
         program_counter      <= pc_nxt;
         next_program_counter <= npc_nxt;
         annul_pend_r         <= annul_next;
      end
   end

   // -------------------------------------------------
   // Window pointer and traps
   // -------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_window_pointer <= 3'h0;
         trap_overflow          <= 1'b0;
         trap_underflow         <= 1'b0;
      end else begin
         if (win_op & ~win_bad)
            current_window_pointer <= new_cwp;
         // Sticky until software clears; a new trap beats the clear
         if (win_bad & (instr_op == dbws_pkg::DBWS_OP_SAVE))
            trap_overflow <= 1'b1;
         else if (psel & penable & pwrite & (paddr == `DBWS_REG_CTRL)
                  & pwdata[`DBWS_CTRL_CLRTRAP])
            trap_overflow <= 1'b0;
         if (win_bad & (instr_op == dbws_pkg::DBWS_OP_RESTORE))
            trap_underflow <= 1'b1;
         else if (psel & penable & pwrite & (paddr == `DBWS_REG_CTRL)
                  & pwdata[`DBWS_CTRL_CLRTRAP])
            trap_underflow <= 1'b0;
      end
   end

   // -------------------------------------------------
   // Register file write
   // -------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rf_wr_en     <= 1'b0;
         rf_wr_addr   <= 5'h00;
         rf_wr_window <= 3'h0;
         rf_wr_data   <= 32'h0000_0000;
      end else begin
         rf_wr_en     <= 1'b0;
         rf_wr_window <= current_window_pointer;
         if (slot_exec & (instr_op == dbws_pkg::DBWS_OP_CALL)) begin
            rf_wr_en   <= 1'b1;
            rf_wr_addr <= `DBWS_LINK_REG;
            rf_wr_data <= program_counter;
         end else if (slot_exec & (instr_op == dbws_pkg::DBWS_OP_JUMP_AND_LINK)) begin
            rf_wr_en   <= (dest_field != 5'h00);
            rf_wr_addr <= dest_field;
            rf_wr_data <= program_counter;
         end else if (win_op & ~win_bad) begin
            // Operands read in old window; sum lands in new window
            rf_wr_en     <= (dest_field != 5'h00);
            rf_wr_addr   <= dest_field;
            rf_wr_window <= new_cwp;
            rf_wr_data   <= src_sum(first_source_val, second_source_val,
                                    imm_flag, signed_immediate_field);
         end
      end
   end

   // -------------------------------------------------
   // APB registers
   // -------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
         wim_r <= `DBWS_WIM_RESET;
      end else if (psel & penable & pwrite) begin
         if (paddr == `DBWS_REG_CTRL)
            run_r <= pwdata[`DBWS_CTRL_RUN_BIT];
         if (paddr == `DBWS_REG_WIM)
            wim_r <= {24'h00_0000, pwdata[7:0]};
      end
   end

   assign pready = 1'b1;
   always_comb begin
      pslverr = 1'b0;
      rd_mux  = 32'h0000_0000;
      unique case (paddr)
         `DBWS_REG_CTRL:   rd_mux = {31'h0000_0000, run_r};
         `DBWS_REG_STATUS: rd_mux = {24'h00_0000, trap_underflow, trap_overflow,
                                     annul_pend_r, 2'b00, current_window_pointer};
         `DBWS_REG_WIM:    rd_mux = wim_r;
         `DBWS_REG_PC:     rd_mux = program_counter;
         `DBWS_REG_NPC:    rd_mux = next_program_counter;
         default:          pslverr = psel & penable;
      endcase
   end

   // Read word latched in setup so it leaves a flop with no wait state
   // Limitation: a register moving during the access phase is not seen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel & ~penable)
         prdata <= rd_mux;
   end

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   chk_seq_advance: assert property (@(posedge pclk) disable iff (!presetn)
      step |=> program_counter == $past(next_program_counter))
      else $error("pc did not take npc");
   chk_link_call: assert property (@(posedge pclk) disable iff (!presetn)
      slot_exec && instr_op == dbws_pkg::DBWS_OP_CALL |=>
         rf_wr_en && rf_wr_addr == 5'h0F && rf_wr_data == $past(program_counter))
      else $error("call link write wrong");
   chk_annul_nop: assert property (@(posedge pclk) disable iff (!presetn)
      annul_pend_r |-> !rf_wr_en ##0 1'b1 ##1 !rf_wr_en)
      else $error("annulled slot wrote state");
   chk_annul_zero: assert property (@(posedge pclk) disable iff (!presetn)
      step && is_branch && !annul_flag && !annul_pend_r |=> !annul_pend_r)
      else $error("slot annulled with flag clear");
   chk_annul_always: assert property (@(posedge pclk) disable iff (!presetn)
      slot_exec && is_branch && annul_flag && br_always |=> annul_pend_r)
      else $error("branch always did not annul");
   chk_cond_taken: assert property (@(posedge pclk) disable iff (!presetn)
      slot_exec && is_branch && annul_flag && !br_always && !br_never && br_cond_true
         |=> !annul_pend_r)
      else $error("taken conditional annulled");
   chk_win_save: assert property (@(posedge pclk) disable iff (!presetn)
      win_op && !win_bad && instr_op == dbws_pkg::DBWS_OP_SAVE
         |=> current_window_pointer == 3'($past(current_window_pointer) - 3'h1))
      else $error("save did not decrement window");
   chk_win_trap: assert property (@(posedge pclk) disable iff (!presetn)
      win_bad |=> $stable(current_window_pointer) && (trap_overflow || trap_underflow))
      else $error("invalid window not suppressed");
   chk_taken_target: assert property (@(posedge pclk) disable iff (!presetn)
      slot_exec && taken && !is_branch |=> next_program_counter == $past(target))
      else $error("npc not at target");
   chk_seq_untaken: assert property (@(posedge pclk) disable iff (!presetn)
      step && !(slot_exec && taken)
         |=> next_program_counter == $past(next_program_counter) + `DBWS_INSTR_BYTES)
      else $error("npc not sequential");
   chk_annul_untaken: assert property (@(posedge pclk) disable iff (!presetn)
      slot_exec && is_branch && annul_flag && !taken |=> annul_pend_r)
      else $error("untaken branch did not annul");
   chk_annul_other: assert property (@(posedge pclk) disable iff (!presetn)
      slot_exec && !is_branch |=> !annul_pend_r)
      else $error("non-branch annulled slot");
   chk_link_jump_and_link: assert property (@(posedge pclk) disable iff (!presetn)
      slot_exec && instr_op == dbws_pkg::DBWS_OP_JUMP_AND_LINK && dest_field != 5'h00 |=>
         rf_wr_en && rf_wr_addr == $past(dest_field)
         && rf_wr_data == $past(program_counter))
      else $error("jump link write wrong");
   chk_r0_write: assert property (@(posedge pclk) disable iff (!presetn)
      rf_wr_en |-> rf_wr_addr != 5'h00)
      else $error("write to register zero");
   chk_rf_window: assert property (@(posedge pclk) disable iff (!presetn)
      win_op && !win_bad && dest_field != 5'h00
         |=> rf_wr_en && rf_wr_window == current_window_pointer)
      else $error("sum not in new window");
   chk_win_restore: assert property (@(posedge pclk) disable iff (!presetn)
      win_op && !win_bad && instr_op == dbws_pkg::DBWS_OP_RESTORE
         |=> current_window_pointer == 3'($past(current_window_pointer) + 3'h1))
      else $error("restore did not increment window");
   chk_win_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      win_op && !win_bad && instr_op == dbws_pkg::DBWS_OP_RESTORE
         && current_window_pointer == `DBWS_CWP_MAX |=> current_window_pointer == 3'h0)
      else $error("window pointer did not wrap");
   chk_trap_over: assert property (@(posedge pclk) disable iff (!presetn)
      win_bad && instr_op == dbws_pkg::DBWS_OP_SAVE |=> trap_overflow)
      else $error("save overflow not flagged");
   chk_trap_under: assert property (@(posedge pclk) disable iff (!presetn)
      win_bad && instr_op == dbws_pkg::DBWS_OP_RESTORE |=> trap_underflow)
      else $error("restore underflow not flagged");
endmodule : dbws_seq
`default_nettype wire
